// ==== rtl/fsfc_pkg.sv ====
package fsfc_pkg;

    // hardware security byte field positions
    localparam int unsigned HSB_DBL_SPEED = 7;
    localparam int unsigned HSB_BOOT_JUMP = 6;
    localparam int unsigned HSB_OSC_B = 5;
    localparam int unsigned HSB_RSVD = 4;
    localparam int unsigned HSB_EXPANDED_RAM_INHIBIT_FUSE_INH = 3;
    localparam int unsigned HSB_LOCK_MSB = 2;

    // default and erased patterns (0 = programmed)
    localparam logic [7:0] HSB_DEFAULT = 8'hbb;
    localparam logic [7:0] HSB_ERASED = 8'hff;
    localparam logic [7:0] SBV_DEFAULT = 8'hfc;
    localparam logic [7:0] BSB_DEFAULT = 8'hff;
    localparam logic [7:0] SSB_DEFAULT = 8'hff;
    localparam logic [7:0] SSB_RSVD_MASK = 8'hfc;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // identity copies, values arbitrary
    localparam logic [7:0] ID_MFR = 8'h11;
    localparam logic [7:0] ID_FAMILY = 8'h22;
    localparam logic [7:0] ID_MEMORY = 8'h33;
    localparam logic [7:0] ID_NAME_REV = 8'h44;

    // extra flash page byte indices
    localparam logic [2:0] XAF_SBV = 3'h0;
    localparam logic [2:0] XAF_HSB = 3'h1;
    localparam logic [2:0] XAF_BSB = 3'h2;
    localparam logic [2:0] XAF_SSB = 3'h3;
    localparam logic [2:0] XAF_MFR = 3'h4;
    localparam logic [2:0] XAF_ID1 = 3'h5;
    localparam logic [2:0] XAF_ID2 = 3'h6;
    localparam logic [2:0] XAF_ID3 = 3'h7;

    // boot addresses
    localparam logic [15:0] BOOT_APP = 16'h0000;
    localparam logic [15:0] BOOT_LOADER = 16'hf800;

    // security levels
    localparam logic [2:0] LVL_1 = 3'h1;
    localparam logic [2:0] LVL_2 = 3'h2;
    localparam logic [2:0] LVL_3 = 3'h3;
    localparam logic [2:0] LVL_4 = 3'h4;

    typedef enum logic [3:0] {
        PP_RD_CODE = 4'h0,
        PP_WR_CODE = 4'h1,
        PP_RD_EE = 4'h2,
        PP_WR_EE = 4'h3,
        PP_RD_HSB = 4'h4,
        PP_WR_HSB = 4'h5,
        PP_RD_XAF = 4'h6,
        PP_WR_XAF = 4'h7,
        PP_RD_ID = 4'h8,
        PP_ERASE = 4'h9
    } fsfc_pp_cmd_e;

    typedef enum logic [1:0] {
        API_RD_CODE = 2'h0,
        API_WR_CODE = 2'h1,
        API_RD_XAF = 2'h2,
        API_WR_XAF = 2'h3
    } fsfc_api_cmd_e;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b00,
        ST_RUN = 2'b01
    } fsfc_state_e;

endpackage

// ==== rtl/fsfc_fuse_config.sv ====
// Contract
// - zero means programmed, one unprogrammed
// - programmed bit 7 gives six-clock cycle
// - bit 6 picks boot 0000h or F800h
// - programmed bit 5 starts oscillator B
// - programmed bit 3 inhibits expanded RAM; code raises the inhibit output when bit 3 is one
// - hardware byte reached only by parallel port
// - extra page only via API or parallel
// - all lock bits unprogrammed: no locks
// - parallel level 2 blocks external reads, writes
// - level 2 keeps in-system programming allowed
// - parallel level 3 blocks verify, EEPROM
// - parallel level 4 blocks external execution
// - parallel locks never gate in-system access
// - chip erase clears flash and hardware byte
// - identification always readable in parallel
// - page holds hardware byte copy, default
// - software byte locks in bits 1-0
// - software level 2 refuses in-system writes
// - software level 3 also refuses verify
// - page holds read-only identity bytes
// - strap pins at reset force bootloader
`timescale 1ns/1ps
`default_nettype none

module fsfc_fuse_config (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic external_access_pin_i,
    input wire logic program_strobe_i,
    input wire logic pp_req_i,
    input wire fsfc_pkg::fsfc_pp_cmd_e pp_cmd_i,
    input wire logic [15:0] pp_addr_i,
    input wire logic [7:0] pp_wdata_i,
    output logic pp_ack_o,
    output logic pp_denied_o,
    output logic [7:0] pp_rdata_o,
    input wire logic api_req_i,
    input wire fsfc_pkg::fsfc_api_cmd_e api_cmd_i,
    input wire logic [15:0] api_addr_i,
    input wire logic [7:0] api_wdata_i,
    output logic api_ack_o,
    output logic api_denied_o,
    output logic [7:0] api_rdata_o,
    output logic flash_req_o,
    output logic flash_we_o,
    output logic flash_erase_o,
    output logic flash_eeprom_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_wdata_o,
    output logic cfg_valid_o,
    output logic double_speed_o,
    output logic [15:0] boot_addr_o,
    output logic boot_loader_forced_o,
    output logic osc_b_select_o,
    output logic expanded_ram_inhibit_fuse_enable_o,
    output logic code_table_read_block_o,
    output logic ext_access_eff_o,
    output logic ext_exec_block_o,
    output logic [2:0] parallel_level_o,
    output logic [2:0] insystem_level_o
);
    import fsfc_pkg::*;

    typedef struct packed {
        fsfc_state_e st;
        logic [7:0] hardware_security_fuse_byte;
        logic [7:0] software_boot_vector;
        logic [7:0] boot_status_byte;
        logic [7:0] software_security_lock_byte;
        logic [7:0] cfg;
        logic ea_lat;
        logic boot_force;
        logic pp_ack;
        logic pp_deny;
        logic [7:0] pp_rdata;
        logic api_ack;
        logic api_deny;
        logic [7:0] api_rdata;
        logic fl_req;
        logic fl_we;
        logic fl_erase;
        logic fl_ee;
        logic [15:0] fl_addr;
        logic [7:0] fl_wdata;
    } fsfc_regs_s;

    localparam fsfc_regs_s REGS_RST = '{
        st: ST_CAPTURE,
        hardware_security_fuse_byte: HSB_DEFAULT,
        software_boot_vector: SBV_DEFAULT,
        boot_status_byte: BSB_DEFAULT,
        software_security_lock_byte: SSB_DEFAULT,
        cfg: HSB_DEFAULT,
        ea_lat: 1'b1,
        boot_force: 1'b0,
        pp_ack: 1'b0,
        pp_deny: 1'b0,
        pp_rdata: DATA_ZERO,
        api_ack: 1'b0,
        api_deny: 1'b0,
        api_rdata: DATA_ZERO,
        fl_req: 1'b0,
        fl_we: 1'b0,
        fl_erase: 1'b0,
        fl_ee: 1'b0,
        fl_addr: BOOT_APP,
        fl_wdata: DATA_ZERO
    };

    fsfc_regs_s s_r;
    fsfc_regs_s s_nxt;
    logic [2:0] plvl;
    logic [2:0] slvl;
    logic [2:0] rlvl;

    // parallel lock level, a zero bit is programmed
    function automatic logic [2:0] par_level(input logic [2:0] lb);
        if (!lb[2]) begin
            return LVL_4;
        end else if (!lb[1]) begin
            return LVL_3;
        end else if (!lb[0]) begin
            return LVL_2;
        end
        return LVL_1;
    endfunction

    // in-system lock level from the software byte
    function automatic logic [2:0] isp_level(input logic [1:0] lb);
        if (!lb[1]) begin
            return LVL_3;
        end else if (!lb[0]) begin
            return LVL_2;
        end
        return LVL_1;
    endfunction

    // extra page read, identity bytes are constants
    function automatic logic [7:0] xaf_rd(input logic [2:0] idx,
                                          input fsfc_regs_s s);
        case (idx)
            XAF_SBV: return s.software_boot_vector;
            XAF_HSB: return s.hardware_security_fuse_byte | (8'h01 << HSB_RSVD);
            XAF_BSB: return s.boot_status_byte;
            XAF_SSB: return s.software_security_lock_byte;
            XAF_MFR: return ID_MFR;
            XAF_ID1: return ID_FAMILY;
            XAF_ID2: return ID_MEMORY;
            default: return ID_NAME_REV;
        endcase
    endfunction

    // software byte write: locks only advance, reserved stay one
    function automatic logic [7:0] ssb_wr(input logic [7:0] cur,
                                          input logic [7:0] wd);
        return (cur & wd) | SSB_RSVD_MASK;
    endfunction

    // live levels gate programmer and in-system access
    assign plvl = par_level(s_r.hardware_security_fuse_byte[HSB_LOCK_MSB:0]);
    assign slvl = isp_level(s_r.software_security_lock_byte[1:0]);
    // run-time level comes from the byte sampled at reset
    assign rlvl = par_level(s_r.cfg[HSB_LOCK_MSB:0]);

    // next-state logic for capture, both ports and the fuses
    always_comb begin
        s_nxt = s_r;
        s_nxt.pp_ack = 1'b0;
        s_nxt.pp_deny = 1'b0;
        s_nxt.pp_rdata = DATA_ZERO;
        s_nxt.api_ack = 1'b0;
        s_nxt.api_deny = 1'b0;
        s_nxt.api_rdata = DATA_ZERO;
        s_nxt.fl_req = 1'b0;
        s_nxt.fl_we = 1'b0;
        s_nxt.fl_erase = 1'b0;
        s_nxt.fl_ee = 1'b0;
        // sample fuses and strap pins once after reset release
        case (s_r.st)
            ST_CAPTURE: begin
                s_nxt.cfg = s_r.hardware_security_fuse_byte;
                s_nxt.ea_lat = external_access_pin_i;
                s_nxt.boot_force = external_access_pin_i &
                                   ~program_strobe_i;
                s_nxt.st = ST_RUN;
            end
            ST_RUN: begin
                s_nxt.st = ST_RUN;
            end
            default: begin
                s_nxt.st = ST_CAPTURE;
            end
        endcase
        // parallel programmer port has priority
        if (pp_req_i) begin
            s_nxt.pp_ack = 1'b1;
            s_nxt.fl_addr = pp_addr_i;
            s_nxt.fl_wdata = pp_wdata_i;
            case (pp_cmd_i)
                PP_RD_CODE: begin
                    s_nxt.pp_deny = plvl >= LVL_3;
                    s_nxt.fl_req = plvl < LVL_3;
                end
                PP_WR_CODE: begin
                    s_nxt.pp_deny = plvl >= LVL_2;
                    s_nxt.fl_req = plvl < LVL_2;
                    s_nxt.fl_we = 1'b1;
                end
                PP_RD_EE: begin
                    s_nxt.pp_deny = plvl >= LVL_3;
                    s_nxt.fl_req = plvl < LVL_3;
                    s_nxt.fl_ee = 1'b1;
                end
                PP_WR_EE: begin
                    s_nxt.pp_deny = plvl >= LVL_2;
                    s_nxt.fl_req = plvl < LVL_2;
                    s_nxt.fl_we = 1'b1;
                    s_nxt.fl_ee = 1'b1;
                end
                PP_RD_HSB: begin
                    s_nxt.pp_rdata = s_r.hardware_security_fuse_byte;
                end
                PP_WR_HSB: begin
                    // option bits follow data, lock bits only program
                    s_nxt.hardware_security_fuse_byte[7:5] = pp_wdata_i[7:5];
                    s_nxt.hardware_security_fuse_byte[HSB_EXPANDED_RAM_INHIBIT_FUSE_INH] =
                        pp_wdata_i[HSB_EXPANDED_RAM_INHIBIT_FUSE_INH];
                    s_nxt.hardware_security_fuse_byte[HSB_LOCK_MSB:0] =
                        s_r.hardware_security_fuse_byte[HSB_LOCK_MSB:0] &
                        pp_wdata_i[HSB_LOCK_MSB:0];
                end
                PP_RD_XAF: begin
                    s_nxt.pp_rdata = xaf_rd(pp_addr_i[2:0], s_r);
                end
                PP_WR_XAF: begin
                    case (pp_addr_i[2:0])
                        XAF_SBV: s_nxt.software_boot_vector = pp_wdata_i;
                        XAF_BSB: s_nxt.boot_status_byte = pp_wdata_i;
                        XAF_SSB: s_nxt.software_security_lock_byte = ssb_wr(s_r.software_security_lock_byte, pp_wdata_i);
                        default: s_nxt.pp_deny = 1'b1;
                    endcase
                end
                PP_RD_ID: begin
                    // no lock level hides the identification
                    s_nxt.pp_rdata = xaf_rd({1'b1, pp_addr_i[1:0]},
                                            s_r);
                end
                PP_ERASE: begin
                    s_nxt.hardware_security_fuse_byte = HSB_ERASED;
                    s_nxt.software_security_lock_byte = SSB_DEFAULT;
                    s_nxt.fl_req = 1'b1;
                    s_nxt.fl_erase = 1'b1;
                end
                default: begin
                    s_nxt.pp_deny = 1'b1;
                end
            endcase
        end else if (api_req_i) begin
            // in-system side sees only the software byte locks
            s_nxt.api_ack = 1'b1;
            s_nxt.fl_addr = api_addr_i;
            s_nxt.fl_wdata = api_wdata_i;
            case (api_cmd_i)
                API_RD_CODE: begin
                    s_nxt.api_deny = slvl >= LVL_3;
                    s_nxt.fl_req = slvl < LVL_3;
                end
                API_WR_CODE: begin
                    s_nxt.api_deny = slvl >= LVL_2;
                    s_nxt.fl_req = slvl < LVL_2;
                    s_nxt.fl_we = 1'b1;
                end
                API_RD_XAF: begin
                    s_nxt.api_rdata = xaf_rd(api_addr_i[2:0], s_r);
                    if (slvl >= LVL_3) begin
                        s_nxt.api_rdata = DATA_ZERO;
                        s_nxt.api_deny = 1'b1;
                    end
                end
                API_WR_XAF: begin
                    case (api_addr_i[2:0])
                        XAF_SBV: begin
                            s_nxt.api_deny = slvl >= LVL_2;
                            if (slvl < LVL_2) begin
                                s_nxt.software_boot_vector = api_wdata_i;
                            end
                        end
                        XAF_BSB: begin
                            s_nxt.api_deny = slvl >= LVL_2;
                            if (slvl < LVL_2) begin
                                s_nxt.boot_status_byte = api_wdata_i;
                            end
                        end
                        XAF_SSB: begin
                            s_nxt.software_security_lock_byte = ssb_wr(s_r.software_security_lock_byte, api_wdata_i);
                        end
                        default: begin
                            // hardware byte copy and identity stay put
                            s_nxt.api_deny = 1'b1;
                        end
                    endcase
                end
                default: begin
                    s_nxt.api_deny = 1'b1;
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= REGS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // port answers and array strobes
    assign pp_ack_o = s_r.pp_ack;
    assign pp_denied_o = s_r.pp_deny;
    assign pp_rdata_o = s_r.pp_rdata;
    assign api_ack_o = s_r.api_ack;
    assign api_denied_o = s_r.api_deny;
    assign api_rdata_o = s_r.api_rdata;
    assign flash_req_o = s_r.fl_req;
    assign flash_we_o = s_r.fl_we;
    assign flash_erase_o = s_r.fl_erase;
    assign flash_eeprom_o = s_r.fl_ee;
    assign flash_addr_o = s_r.fl_addr;
    assign flash_wdata_o = s_r.fl_wdata;

    // run-time configuration from the sampled byte; level outputs follow the live bytes
    assign cfg_valid_o = s_r.st == ST_RUN;
    assign double_speed_o = ~s_r.cfg[HSB_DBL_SPEED];
    assign boot_loader_forced_o = s_r.boot_force;
    assign boot_addr_o = (s_r.boot_force | ~s_r.cfg[HSB_BOOT_JUMP]) ?
                         BOOT_LOADER : BOOT_APP;
    assign osc_b_select_o = ~s_r.cfg[HSB_OSC_B];
    assign expanded_ram_inhibit_fuse_enable_o = s_r.cfg[HSB_EXPANDED_RAM_INHIBIT_FUSE_INH];
    assign code_table_read_block_o = rlvl >= LVL_2;
    assign ext_access_eff_o = (rlvl >= LVL_2) ? s_r.ea_lat :
                              external_access_pin_i;
    assign ext_exec_block_o = rlvl >= LVL_4;
    assign parallel_level_o = plvl;
    assign insystem_level_o = slvl;

endmodule

`default_nettype wire

// ==== dv/fsfc_fuse_config_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// watches request outcomes, lock levels and captured boot outputs
module fsfc_fuse_config_asserts (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic pp_req_i,
    input wire fsfc_pkg::fsfc_pp_cmd_e pp_cmd_i,
    input wire logic pp_ack_o,
    input wire logic pp_denied_o,
    input wire logic api_req_i,
    input wire fsfc_pkg::fsfc_api_cmd_e api_cmd_i,
    input wire logic api_ack_o,
    input wire logic api_denied_o,
    input wire logic flash_req_o,
    input wire logic flash_we_o,
    input wire logic flash_erase_o,
    input wire logic cfg_valid_o,
    input wire logic double_speed_o,
    input wire logic [15:0] boot_addr_o,
    input wire logic boot_loader_forced_o,
    input wire logic osc_b_select_o,
    input wire logic expanded_ram_inhibit_fuse_enable_o,
    input wire logic [2:0] parallel_level_o,
    input wire logic [2:0] insystem_level_o
);
    import fsfc_pkg::*;

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // a lone parallel request gets exactly one answer pulse
    a_pp_answer_time:
        assert property (pp_req_i ##1 !pp_req_i |-> pp_ack_o ##1 !pp_ack_o)
        else $error("parallel answer timing wrong");
    // a refused request never reaches the array
    a_denied_no_array:
        assert property ((pp_ack_o && pp_denied_o) ||
            (api_ack_o && api_denied_o) |-> !flash_req_o)
        else $error("refused request reached array");
    a_open_write_ok:
        assert property (pp_req_i && pp_cmd_i == PP_WR_CODE &&
            parallel_level_o == LVL_1 |=> !pp_denied_o && flash_we_o)
        else $error("unlocked code write refused");
    a_lvl2_wr_block:
        assert property (pp_req_i && pp_cmd_i == PP_WR_CODE &&
            parallel_level_o >= LVL_2 |=> pp_ack_o && pp_denied_o)
        else $error("locked code write accepted");
    a_lvl3_verify_blk:
        assert property (pp_req_i && pp_cmd_i == PP_RD_CODE &&
            parallel_level_o >= LVL_3 |=> pp_ack_o && pp_denied_o)
        else $error("locked code verify accepted");
    a_id_always_read:
        assert property (pp_req_i && pp_cmd_i == PP_RD_ID |=> !pp_denied_o)
        else $error("identification read refused");
    a_erase_clears:
        assert property (pp_req_i && pp_cmd_i == PP_ERASE |=> flash_req_o &&
            flash_erase_o && parallel_level_o == LVL_1)
        else $error("erase did not clear lock");
    a_isp_wr_block:
        assert property (api_req_i && !pp_req_i && api_cmd_i == API_WR_CODE &&
            insystem_level_o >= LVL_2 |=> api_ack_o && api_denied_o)
        else $error("locked in-system write accepted");
    a_isp_verify_blk:
        assert property (api_req_i && !pp_req_i && api_cmd_i == API_RD_CODE &&
            insystem_level_o == LVL_3 |=> api_ack_o && api_denied_o)
        else $error("locked in-system verify accepted");
    a_isp_free_wr:
        assert property (api_req_i && !pp_req_i && api_cmd_i == API_WR_CODE &&
            insystem_level_o == LVL_1 |=> !api_denied_o && flash_we_o)
        else $error("in-system write gated by parallel lock");
    a_cfg_held:
        assert property (cfg_valid_o && $past(cfg_valid_o) |->
            $stable(double_speed_o) && $stable(osc_b_select_o) &&
            $stable(expanded_ram_inhibit_fuse_enable_o) && $stable(boot_addr_o))
        else $error("captured configuration changed");
    a_strap_boot:
        assert property (boot_loader_forced_o |-> boot_addr_o == BOOT_LOADER)
        else $error("strap did not force bootloader");
endmodule

bind fsfc_fuse_config fsfc_fuse_config_asserts i_fsfc_fuse_config_asserts (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pp_req_i(pp_req_i),
    .pp_cmd_i(pp_cmd_i), .pp_ack_o(pp_ack_o), .pp_denied_o(pp_denied_o),
    .api_req_i(api_req_i), .api_cmd_i(api_cmd_i), .api_ack_o(api_ack_o),
    .api_denied_o(api_denied_o), .flash_req_o(flash_req_o),
    .flash_we_o(flash_we_o), .flash_erase_o(flash_erase_o),
    .cfg_valid_o(cfg_valid_o), .double_speed_o(double_speed_o),
    .boot_addr_o(boot_addr_o), .boot_loader_forced_o(boot_loader_forced_o),
    .osc_b_select_o(osc_b_select_o), .expanded_ram_inhibit_fuse_enable_o(expanded_ram_inhibit_fuse_enable_o),
    .parallel_level_o(parallel_level_o),
    .insystem_level_o(insystem_level_o)
);

`default_nettype wire

// ==== dv/fsfc_prog_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// programmer and in-system firmware stand-in for both request ports
module fsfc_prog_model (
    input wire logic core_clk_i,
    output logic pp_req_o,
    output var fsfc_pkg::fsfc_pp_cmd_e pp_cmd_o,
    output logic [15:0] pp_addr_o,
    output logic [7:0] pp_wdata_o,
    output logic api_req_o,
    output var fsfc_pkg::fsfc_api_cmd_e api_cmd_o,
    output logic [15:0] api_addr_o,
    output logic [7:0] api_wdata_o
);
    import fsfc_pkg::*;

    // idle at time zero
    initial begin
        pp_req_o = 1'b0;
        api_req_o = 1'b0;
        pp_cmd_o = PP_RD_ID;
        api_cmd_o = API_RD_CODE;
        pp_addr_o = 16'h0000;
        api_addr_o = 16'h0000;
        pp_wdata_o = 8'h00;
        api_wdata_o = 8'h00;
    end

    // one-cycle request; released address and data lines show the inverse, not stale data
    task automatic send(input logic in_system_programming, input logic [3:0] cmd,
        input logic [15:0] a, input logic [7:0] wd);
        @(posedge core_clk_i);
        pp_req_o <= !in_system_programming;
        api_req_o <= in_system_programming;
        pp_cmd_o <= fsfc_pp_cmd_e'(cmd);
        api_cmd_o <= fsfc_api_cmd_e'(cmd[1:0]);
        pp_addr_o <= a;
        api_addr_o <= a;
        pp_wdata_o <= wd;
        api_wdata_o <= wd;
        @(posedge core_clk_i);
        pp_req_o <= 1'b0;
        api_req_o <= 1'b0;
        pp_addr_o <= ~a;
        api_addr_o <= ~a;
        pp_wdata_o <= ~wd;
        api_wdata_o <= ~wd;
    endtask
endmodule

`default_nettype wire

// ==== dv/test_flash_security_fuse_config.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_flash_security_fuse_config;
    import fsfc_pkg::*;
    logic clk, arst_n, ea, strb;
    logic pp_req, api_req, pp_ack, pp_den, api_ack, api_den;
    fsfc_pp_cmd_e pp_cmd;
    fsfc_api_cmd_e api_cmd;
    logic [15:0] pp_a, api_a, f_a, boot;
    logic [7:0] pp_wd, api_wd, pp_rd, api_rd, f_wd, r;
    logic f_req, f_we, f_er, f_ee, cfgv, dbl, forced, oscb, expanded_ram_inhibit_fuse, ctrb, eaeff;
    logic exb;
    logic [2:0] plvl, ilvl;
    logic [8:0] exp_q[$];
    logic [7:0] extra_flash_page[8];
    int n_fail = 0;
    int cmp_count = 0;

    fsfc_prog_model i_fsfc_prog_model (.core_clk_i(clk), .pp_req_o(pp_req),
        .pp_cmd_o(pp_cmd), .pp_addr_o(pp_a), .pp_wdata_o(pp_wd),
        .api_req_o(api_req), .api_cmd_o(api_cmd), .api_addr_o(api_a),
        .api_wdata_o(api_wd));

    fsfc_fuse_config i_fsfc_fuse_config (.core_clk_i(clk), .arst_n_i(arst_n),
        .external_access_pin_i(ea), .program_strobe_i(strb),
        .pp_req_i(pp_req), .pp_cmd_i(pp_cmd), .pp_addr_i(pp_a),
        .pp_wdata_i(pp_wd), .pp_ack_o(pp_ack), .pp_denied_o(pp_den),
        .pp_rdata_o(pp_rd), .api_req_i(api_req), .api_cmd_i(api_cmd),
        .api_addr_i(api_a), .api_wdata_i(api_wd), .api_ack_o(api_ack),
        .api_denied_o(api_den), .api_rdata_o(api_rd), .flash_req_o(f_req),
        .flash_we_o(f_we), .flash_erase_o(f_er), .flash_eeprom_o(f_ee),
        .flash_addr_o(f_a), .flash_wdata_o(f_wd), .cfg_valid_o(cfgv),
        .double_speed_o(dbl), .boot_addr_o(boot),
        .boot_loader_forced_o(forced), .osc_b_select_o(oscb),
        .expanded_ram_inhibit_fuse_enable_o(expanded_ram_inhibit_fuse), .code_table_read_block_o(ctrb),
        .ext_access_eff_o(eaeff), .ext_exec_block_o(exb),
        .parallel_level_o(plvl), .insystem_level_o(ilvl));

    // clock at 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (exp_q.size() != 0)
            n_fail++;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // note the expected {denied, rdata}, then let the partner send it
    task automatic op(input logic in_system_programming, input logic [3:0] cmd,
        input logic [15:0] a, input logic [7:0] wd, input logic [8:0] e);
        exp_q.push_back(e);
        i_fsfc_prog_model.send(in_system_programming, cmd, a, wd);
        @(negedge clk);
    endtask

    // answer watcher: oldest note against each answer pulse
    always @(negedge clk) begin
        if (pp_ack === 1'b1)
            chk({7'h0, pp_den, pp_rd}, {7'h0, exp_q.pop_front()});
        else if (api_ack === 1'b1)
            chk({7'h0, api_den, api_rd}, {7'h0, exp_q.pop_front()});
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        arst_n = 1'b0;
        ea = 1'b1;
        strb = 1'b0;
        extra_flash_page = '{SBV_DEFAULT, HSB_DEFAULT, BSB_DEFAULT, SSB_DEFAULT, ID_MFR,
            ID_FAMILY, ID_MEMORY, ID_NAME_REV};
        void'($urandom(54927));
        repeat (10) @(posedge clk);
        chk({cfgv, 9'h0, plvl, ilvl}, {10'h0, LVL_4, LVL_1});
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({cfgv, forced, dbl, oscb, expanded_ram_inhibit_fuse, exb}, 6'h33);
        chk(boot, BOOT_LOADER);
        $display("test defaults done");
        // page, identity and level 4 refusals
        for (int i = 0; i < 8; i++)
            op(0, PP_RD_XAF, 16'(i), 8'h00, {1'b0, extra_flash_page[i]});
        for (int i = 0; i < 4; i++) begin
            op(0, PP_RD_ID, 16'(i), 8'h00, {1'b0, extra_flash_page[i+4]});
            op(0, PP_WR_XAF, 16'(i + 4), 8'h00, 9'h100);
        end
        for (int c = 0; c < 4; c++)
            op(0, 4'(c), 16'($urandom), 8'($urandom), 9'h100);
        op(1, API_WR_CODE, 16'($urandom), 8'h5a, 9'h000);
        // after loading, boot status byte cleared over the in-system port
        op(1, API_WR_XAF, 16'(XAF_BSB), 8'h00, 9'h000);
        op(0, PP_RD_XAF, 16'(XAF_BSB), 8'h00, 9'h000);
        $display("test level four done");
        // chip erase opens everything before a new load
        op(0, PP_ERASE, 16'h0000, 8'h00, 9'h000);
        chk({f_req, f_we, f_er, f_ee}, 4'ha);
        chk(f_a, 16'h0000);
        chk(plvl, LVL_1);
        op(0, PP_RD_HSB, 16'h0000, 8'h00, {1'b0, HSB_ERASED});
        r = 8'($urandom);
        op(0, PP_WR_CODE, 16'($urandom), r, 9'h000);
        chk(f_wd, r);
        op(0, PP_WR_EE, 16'($urandom), r, 9'h000);
        chk({f_req, f_we, f_er, f_ee}, 4'hd);
        // level 2, then 3, then 4, set only once contents are verified
        op(0, PP_WR_HSB, 16'h0000, 8'hfe, 9'h000);
        chk(plvl, LVL_2);
        op(0, PP_WR_CODE, 16'($urandom), r, 9'h100);
        op(0, PP_WR_EE, 16'($urandom), r, 9'h100);
        op(0, PP_RD_CODE, 16'($urandom), r, 9'h000);
        op(0, PP_RD_EE, 16'($urandom), r, 9'h000);
        op(1, API_WR_CODE, 16'($urandom), r, 9'h000);
        op(0, PP_WR_HSB, 16'h0000, 8'hfd, 9'h000);
        chk(plvl, LVL_3);
        op(0, PP_RD_CODE, 16'($urandom), r, 9'h100);
        op(0, PP_RD_EE, 16'($urandom), r, 9'h100);
        op(0, PP_WR_HSB, 16'h0000, 8'h00, 9'h000);
        op(0, PP_RD_HSB, 16'h0000, 8'h00, 9'h010);
        chk({dbl, oscb, expanded_ram_inhibit_fuse, plvl}, {3'b001, LVL_4});
        $display("test parallel locks done");
        // in-system locks, reserved bits written as ones
        op(1, API_WR_XAF, 16'(XAF_SSB), 8'hfe, 9'h000);
        chk(ilvl, LVL_2);
        op(1, API_WR_CODE, 16'($urandom), r, 9'h100);
        op(1, API_RD_CODE, 16'($urandom), r, 9'h000);
        op(1, API_WR_XAF, 16'(XAF_SSB), 8'hfc, 9'h000);
        chk(ilvl, LVL_3);
        op(1, API_RD_CODE, 16'($urandom), r, 9'h100);
        op(1, API_RD_XAF, 16'(XAF_SBV), 8'h00, 9'h100);
        op(0, PP_RD_XAF, 16'(XAF_SSB), 8'h00, 9'h0fc);
        $display("test in-system locks done");
        // second reset without strap: latched pin, defaults back
        @(posedge clk);
        arst_n <= 1'b0;
        ea <= 1'b0;
        strb <= 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        ea <= 1'b1;
        @(negedge clk);
        chk({forced, eaeff, ctrb, 7'h0, plvl, ilvl}, {3'b001, 7'h0, LVL_4,
            LVL_1});
        chk(boot, BOOT_LOADER);
        $display("test second reset done");
        close_out();
    end
endmodule

`default_nettype wire
